// file: src/iaoe_core.sv
// execute slice for increment, increment-skip and the two or opcodes
`timescale 1ns/100ps
`default_nettype none
module iaoe_core #(
   parameter int unsigned DATA_W = iaoe_pkg::DATA_W
) (
   input  wire logic                  ref_clk,
   input  wire logic                  rstn,
   input  wire logic                  insn_valid,
   input  wire logic [11:0]           insn,
   input  wire logic [DATA_W-1:0]     file_rdata,
   input  wire logic [DATA_W-1:0]     acc_in,
   output logic      [4:0]            file_addr,
   output logic                       file_we,
   output logic      [DATA_W-1:0]     file_wdata,
   output logic                       acc_we,
   output logic      [DATA_W-1:0]     acc_wdata,
   output logic                       zero_we,
   output logic                       zero_flag,
   output logic                       flush_next,
   output logic                       busy_idle,
   output logic                       done
);
   iaoe_pkg::iaoe_op_e    op;
   iaoe_pkg::iaoe_state_e state;
   logic [DATA_W-1:0]     result;
   logic                  dest_file;
   logic                  res_zero;
   logic                  accepted;
   logic                  handled;
   logic [DATA_W-1:0]     literal;
   logic                  skip_now;

   iaoe_decode u_decode (
      .insn (insn),
      .op   (op)
   );

   function automatic logic is_zero(
      input logic [DATA_W-1:0] v
   );
      is_zero = (v == DATA_W'(iaoe_pkg::DATA_ZERO));
   endfunction : is_zero

   function automatic logic has_result(
      input iaoe_pkg::iaoe_op_e o
   );
      has_result = (o != iaoe_pkg::IAOE_OP_NONE);
   endfunction : has_result

   function automatic logic in_idle(
      input iaoe_pkg::iaoe_state_e s
   );
      in_idle = (s == iaoe_pkg::IAOE_ST_IDLE);
   endfunction : in_idle

   // the literal form has no destination bit: bit 5 is literal data
   function automatic logic to_file(
      input iaoe_pkg::iaoe_op_e o,
      input logic               d
   );
      to_file = (o != iaoe_pkg::IAOE_OP_ORL) && d;
   endfunction : to_file

   function automatic logic keeps_zero(
      input iaoe_pkg::iaoe_op_e o
   );
      keeps_zero = (o == iaoe_pkg::IAOE_OP_INCS);
   endfunction : keeps_zero

   function automatic logic skip_fires(
      input iaoe_pkg::iaoe_op_e o,
      input logic               z
   );
      skip_fires = (o == iaoe_pkg::IAOE_OP_INCS) && z;
   endfunction : skip_fires

   // while inserting the idle op the fetched word is ignored
   assign accepted  = insn_valid && !in_idle(state);
   assign handled   = accepted && has_result(op);
   assign dest_file = insn[iaoe_pkg::DEST_BIT];
   assign literal   = DATA_W'(insn[iaoe_pkg::DATA_W-1:0]);
   assign skip_now  = handled && skip_fires(op, res_zero);

   always_comb begin
      result = DATA_W'(iaoe_pkg::DATA_ZERO);
      case (op)
         iaoe_pkg::IAOE_OP_INC,
         iaoe_pkg::IAOE_OP_INCS: begin
            result = file_rdata + DATA_W'(iaoe_pkg::DATA_ONE);
         end
         iaoe_pkg::IAOE_OP_ORL: begin
            result = acc_in | literal;
         end
         iaoe_pkg::IAOE_OP_ORF: begin
            result = acc_in | file_rdata;
         end
         default: begin
            result = DATA_W'(iaoe_pkg::DATA_ZERO);
         end
      endcase
   end
   assign res_zero = is_zero(result);

   // address and data follow the word every cycle; only the strobes
   // decide whether anything is written, which keeps the muxes small
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         file_addr <= iaoe_pkg::ADDR_ZERO;
      end else begin
         file_addr <= insn[iaoe_pkg::ADDR_W-1:0];
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         file_wdata <= DATA_W'(iaoe_pkg::DATA_ZERO);
         acc_wdata  <= DATA_W'(iaoe_pkg::DATA_ZERO);
      end else begin
         file_wdata <= result;
         acc_wdata  <= result;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         file_we <= 1'b0;
      end else begin
         file_we <= 1'b0;
         if (handled && to_file(op, dest_file)) begin
            file_we <= 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         acc_we <= 1'b0;
      end else begin
         acc_we <= 1'b0;
         if (handled && !to_file(op, dest_file)) begin
            acc_we <= 1'b1;
         end
      end
   end

   // the skip form leaves the zero flag alone
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         zero_we <= 1'b0;
      end else begin
         zero_we <= 1'b0;
         if (handled && !keeps_zero(op)) begin
            zero_we <= 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         zero_flag <= 1'b0;
      end else if (handled && !keeps_zero(op)) begin
         zero_flag <= res_zero;
      end
   end

   // one idle cycle replaces the prefetched word
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state <= iaoe_pkg::IAOE_ST_RUN;
      end else begin
         case (state)
            iaoe_pkg::IAOE_ST_RUN: begin
               if (skip_now) begin
                  state <= iaoe_pkg::IAOE_ST_IDLE;
               end
            end
            iaoe_pkg::IAOE_ST_IDLE: begin
               state <= iaoe_pkg::IAOE_ST_RUN;
            end
            default: begin
               state <= iaoe_pkg::IAOE_ST_RUN;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         flush_next <= 1'b0;
      end else begin
         flush_next <= skip_now;
      end
   end

   // high for exactly the idle cycle, in step with the state register
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         busy_idle <= 1'b0;
      end else begin
         busy_idle <= skip_now;
      end
   end

   // a zero skip reports completion only at the end of its idle cycle
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         done <= 1'b0;
      end else if (in_idle(state)) begin
         done <= 1'b1;
      end else begin
         done <= handled && !skip_now;
      end
   end
endmodule : iaoe_core
`default_nettype wire

// file: src/iaoe_pkg.sv
// opcodes, fields and constants of the increment / or execute slice
package iaoe_pkg;
   localparam int unsigned INSN_W = 12;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned ADDR_W = 5;
   // opcode match patterns on instruction bits 11:6 (file forms)
   localparam logic [5:0] OP_INCREMENT_FILE = 6'h0A;
   localparam logic [5:0] OP_INCREMENT_SKIP = 6'h0F;
   localparam logic [5:0] OP_OR_ACC_FILE    = 6'h04;
   // literal form matches bits 11:8
   localparam logic [3:0] OP_OR_LITERAL     = 4'hD;
   localparam int unsigned OP6_HI  = 11;
   localparam int unsigned OP6_LO  = 6;
   localparam int unsigned OP4_LO  = 8;
   localparam int unsigned DEST_BIT = 5;
   localparam logic [7:0] DATA_ZERO = 8'h00;
   localparam logic [7:0] DATA_ONE  = 8'h01;
   localparam logic [4:0] ADDR_ZERO = 5'h00;
   typedef enum logic [2:0] {
      IAOE_OP_NONE = 3'b000,
      IAOE_OP_INC  = 3'b001,
      IAOE_OP_INCS = 3'b010,
      IAOE_OP_ORL  = 3'b011,
      IAOE_OP_ORF  = 3'b100
   } iaoe_op_e;
   typedef enum logic [0:0] {
      IAOE_ST_RUN  = 1'b0,
      IAOE_ST_IDLE = 1'b1
   } iaoe_state_e;
endpackage : iaoe_pkg

// file: src/iaoe_decode.sv
// opcode decoder of the increment / or execute slice
`timescale 1ns/100ps
`default_nettype none
module iaoe_decode (
   input  wire logic [11:0]      insn,
   output var iaoe_pkg::iaoe_op_e op
);
   always_comb begin
      if (insn[iaoe_pkg::OP6_HI:iaoe_pkg::OP6_LO] ==
          iaoe_pkg::OP_INCREMENT_FILE) begin
         op = iaoe_pkg::IAOE_OP_INC;
      end else if (insn[iaoe_pkg::OP6_HI:iaoe_pkg::OP6_LO] ==
                   iaoe_pkg::OP_INCREMENT_SKIP) begin
         op = iaoe_pkg::IAOE_OP_INCS;
      end else if (insn[iaoe_pkg::OP6_HI:iaoe_pkg::OP6_LO] ==
                   iaoe_pkg::OP_OR_ACC_FILE) begin
         op = iaoe_pkg::IAOE_OP_ORF;
      end else if (insn[iaoe_pkg::OP6_HI:iaoe_pkg::OP4_LO] ==
                   iaoe_pkg::OP_OR_LITERAL) begin
         op = iaoe_pkg::IAOE_OP_ORL;
      end else begin
         op = iaoe_pkg::IAOE_OP_NONE;
      end
   end
endmodule : iaoe_decode
`default_nettype wire

// file: dv/iaoe_monitor.sv
// port assertions of the increment / or execute slice
`timescale 1ns/100ps
`default_nettype none
module iaoe_monitor (
   input wire logic        ref_clk,
   input wire logic        rstn,
   input wire logic        insn_valid,
   input wire logic [11:0] insn,
   input wire logic [7:0]  file_rdata,
   input wire logic [7:0]  acc_in,
   input wire logic        file_we,
   input wire logic [7:0]  file_wdata,
   input wire logic        acc_we,
   input wire logic [7:0]  acc_wdata,
   input wire logic        zero_we,
   input wire logic        flush_next,
   input wire logic        busy_idle,
   input wire logic        done
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   logic go;
   // the idle cycle refuses whatever is presented
   assign go = insn_valid && !busy_idle;
   a_inc_result: assert property (go && insn[11:6] == 6'h0A |=>
      zero_we && file_wdata == $past(file_rdata) + 8'h01) else $error("inc");
   a_skip_flags: assert property (go && insn[11:6] == 6'h0F |=>
      !zero_we && file_we == $past(insn[5])) else $error("skip");
   a_skip_idle: assert property (go && insn[11:6] == 6'h0F &&
      file_rdata == 8'hFF |=> flush_next && !done ##1 done && !acc_we)
      else $error("idle");
   a_orl_result: assert property (go && insn[11:8] == 4'hD |=>
      acc_wdata == ($past(acc_in) | $past(insn[7:0]))) else $error("orl");
   a_orf_route: assert property (go && insn[11:6] == 6'h04 |=>
      acc_we == !$past(insn[5])) else $error("orf");
endmodule : iaoe_monitor
`default_nettype wire

// file: dv/iaoe_datapath_model.sv
// file registers and accumulator beside the execute slice
`timescale 1ns/100ps
`default_nettype none
module iaoe_datapath_model (
   input  wire logic       ref_clk,
   input  wire logic       rstn,
   input  wire logic [4:0] rd_addr,
   input  wire logic [4:0] file_addr,
   input  wire logic       file_we,
   input  wire logic [7:0] file_wdata,
   input  wire logic       acc_we,
   input  wire logic [7:0] acc_wdata,
   output logic      [7:0] file_rdata,
   output logic      [7:0] acc
);
   logic [7:0] mem [32];
   assign file_rdata = mem[rd_addr];
   // seeded so address 7 holds ff and wraps on increment
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         for (int k = 0; k < 32; k++)
            mem[k] <= 8'hF8 + 8'(k);
         acc <= 8'h00;
      end else begin
         if (file_we) mem[file_addr] <= file_wdata;
         if (acc_we) acc <= acc_wdata;
      end
   end
endmodule : iaoe_datapath_model
`default_nettype wire

// file: dv/iaoe_bench.sv
// self-checking bench of the increment / or execute slice
`timescale 1ns/100ps
`default_nettype none
module iaoe_bench;
   logic        ref_clk = 0, rstn = 0, insn_valid = 0;
   logic        file_we, acc_we, zero_we, zero_flag;
   logic        flush_next, busy_idle, done, zf = 0;
   logic [11:0] insn = 12'h000;
   logic [7:0]  file_rdata, acc_in, file_wdata, acc_wdata;
   logic [4:0]  file_addr;
   logic [31:0] rng = 32'h57CE;
   int          err_total = 0, checks_done = 0;
   always #4 ref_clk = ~ref_clk;
   iaoe_core uut (.ref_clk, .rstn, .insn_valid, .insn, .file_rdata, .acc_in,
      .file_addr, .file_we, .file_wdata, .acc_we, .acc_wdata, .zero_we,
      .zero_flag, .flush_next, .busy_idle, .done);
   iaoe_datapath_model dp (.ref_clk, .rstn, .rd_addr(insn[4:0]), .file_addr,
      .file_we, .file_wdata, .acc_we, .acc_wdata, .file_rdata, .acc(acc_in));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs
   function automatic logic [7:0] want(input logic [11:0] i,
      input logic [7:0] f, input logic [7:0] a);
      case (i[11:6])
         6'h0A, 6'h0F: return f + 8'h01;
         6'h04: return f | a;
         default: return a | i[7:0];
      endcase
   endfunction : want
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic end_sim;
      $display("errors %0d checks %0d", err_total, checks_done);
      if (err_total == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : end_sim
   task automatic run(input logic [11:0] i);
      logic [7:0] r;
      logic k, wr, d, fl;
      @(negedge ref_clk);
      insn_valid = 1;
      insn = i;
      #1;
      r = want(i, file_rdata, acc_in);
      k = i[11:6] == 6'h0F;
      wr = i[11:8] == 4'hD || i[11:6] inside {6'h0A, 6'h0F, 6'h04};
      d = i[5] && i[11:8] != 4'hD;
      fl = k && r == 8'h00;
      @(negedge ref_clk);
      // idle cycle gets a live instruction that must be dropped
      insn_valid = fl;
      insn = 12'h2A7;
      chk({file_we, acc_we, zero_we, flush_next, done, busy_idle, 2'h0},
      {wr && d, wr && !d, wr && !k, fl, wr && !fl, fl, 2'h0});
      if (wr) chk(d ? file_wdata : acc_wdata, r);
      // the flag holds through the skip form and unknown words
      if (wr && !k) zf = (r == 8'h00);
      chk(8'(zero_flag), 8'(zf));
      if (wr && d) chk({3'h0, file_addr}, {3'h0, i[4:0]});
      if (fl) begin
         @(negedge ref_clk);
         insn_valid = 0;
         chk({file_we, acc_we, zero_we, done, 4'h0}, 8'h10);
      end
   endtask : run
   initial begin
      repeat (10) @(negedge ref_clk);
      rstn = 1;
      run(12'h3C7);
      run(12'h2A7);
      run(12'hD00);
      run(12'h000);
      repeat (200) begin
         rng = xs(rng);
         case (rng[1:0])
            2'd0: run({6'h0A, rng[7:2]});
            2'd1: run({6'h0F, rng[7:2]});
            2'd2: run({6'h04, rng[7:2]});
            default: run({4'hD, rng[9:2]});
         endcase
      end
      // mid-run reset with a word presented: all outputs drop at once
      @(negedge ref_clk);
      rstn = 0;
      insn_valid = 1;
      @(negedge ref_clk);
      chk({file_we, acc_we, zero_we, zero_flag, flush_next, busy_idle, done,
      1'b0}, 8'h00);
      chk(file_wdata | acc_wdata | {3'h0, file_addr}, 8'h00);
      rstn = 1;
      insn_valid = 0;
      zf = 0;
      run(12'h3C7);
      run(12'h2A7);
      end_sim;
   end
   initial begin
      #20000;
      err_total++;
      end_sim;
   end
endmodule : iaoe_bench
bind iaoe_core iaoe_monitor mon (.ref_clk, .rstn, .insn_valid, .insn,
   .file_rdata, .acc_in, .file_we, .file_wdata, .acc_we, .acc_wdata,
   .zero_we, .flush_next, .busy_idle, .done);
`default_nettype wire
